// ===== include/mie_pkg.sv
/*
 * Shared constants for the instruction execution subset: operation codes,
 * sequencer states, field widths and reset values.
 * Assumes the decoder upstream maps each instruction to one operation code.
 */
package mie_pkg;
    localparam int DATA_W = 8;
    localparam int BIT_SEL_W = 3;
    localparam int OP_W = 4;

    localparam logic [OP_W-1:0] OP_NONE = 4'h0;
    localparam logic [OP_W-1:0] OP_ADD_INTO_MEMORY = 4'h1;
    localparam logic [OP_W-1:0] OP_AND_MEM_TO_WORK = 4'h2;
    localparam logic [OP_W-1:0] OP_AND_LIT_TO_WORK = 4'h3;
    localparam logic [OP_W-1:0] OP_AND_INTO_MEMORY = 4'h4;
    localparam logic [OP_W-1:0] OP_CALL = 4'h5;
    localparam logic [OP_W-1:0] OP_ZERO_WRITE_BYTE = 4'h6;
    localparam logic [OP_W-1:0] OP_ZERO_WRITE_BIT = 4'h7;
    localparam logic [OP_W-1:0] OP_WDOG_CLEAR = 4'h8;

    // All ones: AND is the only writer of the working register in this subset,
    // so a zero reset would pin it at zero and hide every add carry
    localparam logic [DATA_W-1:0] WORK_RST = 8'hff;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BIT_MASK = 8'h01;
    localparam logic FLAG_RST = 1'b0;
    // Return address is the word after the call
    localparam int RET_STEP = 1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CALL_LOAD = 2'b10
    } mie_state_t;
endpackage

// ===== rtl/mie_alu.sv
/*
 * Byte adder and AND unit with the arithmetic flag terms.
 * Purely combinational; operands come from registered or synchronous sources.
 */
module mie_alu
    import mie_pkg::*;
(
    input wire logic [DATA_W-1:0] a_in,
    input wire logic [DATA_W-1:0] b_in,
    output logic [DATA_W-1:0] sum_out,
    output logic [DATA_W-1:0] and_out,
    output logic sign_wrap_out,
    output logic nibble_wrap_out,
    output logic arith_wrap_out
);
    logic [DATA_W:0] full_sum;
    logic [4:0] low_sum;
    logic carry_into_msb;

    always_comb begin
        full_sum = {1'b0, a_in} + {1'b0, b_in};
        low_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
        // Carry into the top bit is recovered from the sum bit and both operand top bits
        carry_into_msb = full_sum[DATA_W-1] ^ a_in[DATA_W-1] ^ b_in[DATA_W-1];
        sum_out = full_sum[DATA_W-1:0];
        and_out = a_in & b_in;
        arith_wrap_out = full_sum[DATA_W];
        nibble_wrap_out = low_sum[4];
        sign_wrap_out = carry_into_msb ^ full_sum[DATA_W];
    end
endmodule

// ===== rtl/mie_core.sv
/*
 * Execution of the add, AND, call, zero-write and watchdog-clear subset.
 * Assumes the decoder presents one operation with its memory byte, literal
 * and program counter in the cycle OP_VALID_IN is high, and holds it
 * while BUSY_OUT is high. Memory, stack and program counter are outside.
 */
module mie_core
    import mie_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PC_W = 12,
    parameter int WDOG_W = 16
) (
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    input wire logic OP_VALID_IN,
    input wire logic [OP_W-1:0] OP_CODE_IN,
    input wire logic [ADDR_W-1:0] MEM_ADDR_IN,
    input wire logic [DATA_W-1:0] MEM_RDATA_IN,
    input wire logic [DATA_W-1:0] LITERAL_IN,
    input wire logic [BIT_SEL_W-1:0] BIT_SEL_IN,
    input wire logic [PC_W-1:0] CALL_TARGET_IN,
    input wire logic [PC_W-1:0] PC_IN,
    input wire logic WDOG_TICK_IN,
    input wire logic EXPIRY_SET_IN,
    input wire logic SLEEP_SET_IN,
    output logic [DATA_W-1:0] WORK_REG_OUT,
    output logic SIGN_WRAP_OUT,
    output logic NULL_RESULT_OUT,
    output logic NIBBLE_WRAP_OUT,
    output logic ARITH_WRAP_OUT,
    output logic MEM_WE_OUT,
    output logic [ADDR_W-1:0] MEM_ADDR_OUT,
    output logic [DATA_W-1:0] MEM_WDATA_OUT,
    output logic STACK_PUSH_OUT,
    output logic [PC_W-1:0] STACK_DATA_OUT,
    output logic PC_LOAD_OUT,
    output logic [PC_W-1:0] PC_VALUE_OUT,
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic [WDOG_W-1:0] WDOG_COUNT_OUT,
    output logic WDOG_EXPIRY_OUT,
    output logic SLEEP_ENTRY_OUT
);
    mie_state_t state_q;
    logic [DATA_W-1:0] work_q;
    logic sign_q, null_q, nib_q, arith_q;
    logic mem_we_q, push_q, pc_load_q, busy_q, done_q;
    logic [ADDR_W-1:0] mem_addr_q;
    logic [DATA_W-1:0] mem_wdata_q, mem_wdata_d;
    logic [PC_W-1:0] stack_data_q, pc_value_q, target_q;
    logic [WDOG_W-1:0] wdog_q;
    logic expiry_q, sleep_q;
    logic take;
    logic [DATA_W-1:0] operand, sum, and_res, bit_cleared;
    logic alu_sign, alu_nib, alu_arith;

    assign take = OP_VALID_IN && (state_q == ST_IDLE);
    assign operand = (OP_CODE_IN == OP_AND_LIT_TO_WORK) ? LITERAL_IN : MEM_RDATA_IN;

    mie_alu u_alu (
        .a_in(work_q),
        .b_in(operand),
        .sum_out(sum),
        .and_out(and_res),
        .sign_wrap_out(alu_sign),
        .nibble_wrap_out(alu_nib),
        .arith_wrap_out(alu_arith)
    );

    for (genvar i = 0; i < DATA_W; i++) begin : g_bitclr
        assign bit_cleared[i] = (BIT_SEL_IN == BIT_SEL_W'(i)) ? 1'b0 : MEM_RDATA_IN[i];
    end

    always_comb begin
        unique case (OP_CODE_IN)
            OP_ADD_INTO_MEMORY: mem_wdata_d = sum;
            OP_AND_INTO_MEMORY: mem_wdata_d = and_res;
            OP_ZERO_WRITE_BIT: mem_wdata_d = bit_cleared;
            default: mem_wdata_d = ZERO_BYTE;
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (take && OP_CODE_IN == OP_CALL) begin
                        state_q <= ST_CALL_LOAD;
                    end
                end
                ST_CALL_LOAD: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
            busy_q <= take && (OP_CODE_IN == OP_CALL);
            done_q <= (take && OP_CODE_IN != OP_CALL) || (state_q == ST_CALL_LOAD);
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            work_q <= WORK_RST;
        end else if (take && (OP_CODE_IN == OP_AND_MEM_TO_WORK
                || OP_CODE_IN == OP_AND_LIT_TO_WORK)) begin
            work_q <= and_res;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            sign_q <= FLAG_RST;
            null_q <= FLAG_RST;
            nib_q <= FLAG_RST;
            arith_q <= FLAG_RST;
        end else if (take) begin
            if (OP_CODE_IN == OP_ADD_INTO_MEMORY) begin
                sign_q <= alu_sign;
                nib_q <= alu_nib;
                arith_q <= alu_arith;
                null_q <= (sum == ZERO_BYTE);
            end else if (OP_CODE_IN == OP_AND_MEM_TO_WORK || OP_CODE_IN == OP_AND_LIT_TO_WORK
                    || OP_CODE_IN == OP_AND_INTO_MEMORY) begin
                null_q <= (and_res == ZERO_BYTE);
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            mem_we_q <= 1'b0;
            mem_addr_q <= '0;
            mem_wdata_q <= ZERO_BYTE;
        end else begin
            mem_we_q <= take && (OP_CODE_IN == OP_ADD_INTO_MEMORY
                || OP_CODE_IN == OP_AND_INTO_MEMORY || OP_CODE_IN == OP_ZERO_WRITE_BYTE
                || OP_CODE_IN == OP_ZERO_WRITE_BIT);
            if (take) begin
                mem_addr_q <= MEM_ADDR_IN;
                mem_wdata_q <= mem_wdata_d;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            push_q <= 1'b0;
            pc_load_q <= 1'b0;
            stack_data_q <= '0;
            pc_value_q <= '0;
            target_q <= '0;
        end else begin
            push_q <= take && (OP_CODE_IN == OP_CALL);
            pc_load_q <= (state_q == ST_CALL_LOAD);
            if (take && OP_CODE_IN == OP_CALL) begin
                stack_data_q <= PC_IN + PC_W'(RET_STEP);
                target_q <= CALL_TARGET_IN;
            end
            if (state_q == ST_CALL_LOAD) begin
                pc_value_q <= target_q;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            wdog_q <= '0;
            expiry_q <= FLAG_RST;
            sleep_q <= FLAG_RST;
        end else begin
            if (take && OP_CODE_IN == OP_WDOG_CLEAR) begin
                wdog_q <= '0;
            end else if (WDOG_TICK_IN && wdog_q != '1) begin
                wdog_q <= wdog_q + WDOG_W'(1);
            end
            // A set arriving with the clear wins so the event is not lost
            if (EXPIRY_SET_IN) begin
                expiry_q <= 1'b1;
            end else if (take && OP_CODE_IN == OP_WDOG_CLEAR) begin
                expiry_q <= 1'b0;
            end
            if (SLEEP_SET_IN) begin
                sleep_q <= 1'b1;
            end else if (take && OP_CODE_IN == OP_WDOG_CLEAR) begin
                sleep_q <= 1'b0;
            end
        end
    end

    assign WORK_REG_OUT = work_q;
    assign SIGN_WRAP_OUT = sign_q;
    assign NULL_RESULT_OUT = null_q;
    assign NIBBLE_WRAP_OUT = nib_q;
    assign ARITH_WRAP_OUT = arith_q;
    assign MEM_WE_OUT = mem_we_q;
    assign MEM_ADDR_OUT = mem_addr_q;
    assign MEM_WDATA_OUT = mem_wdata_q;
    assign STACK_PUSH_OUT = push_q;
    assign STACK_DATA_OUT = stack_data_q;
    assign PC_LOAD_OUT = pc_load_q;
    assign PC_VALUE_OUT = pc_value_q;
    assign BUSY_OUT = busy_q;
    assign DONE_OUT = done_q;
    assign WDOG_COUNT_OUT = wdog_q;
    assign WDOG_EXPIRY_OUT = expiry_q;
    assign SLEEP_ENTRY_OUT = sleep_q;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    sequence s_call_taken;
        take && OP_CODE_IN == OP_CALL;
    endsequence
    sequence s_call_body;
        STACK_PUSH_OUT && BUSY_OUT ##1 PC_LOAD_OUT && !BUSY_OUT;
    endsequence

    chk_add_mem_result: assert property (
        take && OP_CODE_IN == OP_ADD_INTO_MEMORY |=> MEM_WE_OUT
            && MEM_WDATA_OUT == DATA_W'($past(MEM_RDATA_IN) + $past(work_q))
            && ARITH_WRAP_OUT == (9'($past(MEM_RDATA_IN)) + 9'($past(work_q)) > 9'h0ff))
        else $error("add into memory result or carry wrong");
    chk_add_mem_flags: assert property (
        take && OP_CODE_IN == OP_ADD_INTO_MEMORY |=>
            NULL_RESULT_OUT == (MEM_WDATA_OUT == ZERO_BYTE)
            && NIBBLE_WRAP_OUT == (5'($past(MEM_RDATA_IN[3:0])) + 5'($past(work_q[3:0])) > 5'h0f))
        else $error("add into memory null or nibble flag wrong");
    chk_and_mem_work: assert property (
        take && OP_CODE_IN == OP_AND_MEM_TO_WORK |=> !MEM_WE_OUT
            && WORK_REG_OUT == ($past(work_q) & $past(MEM_RDATA_IN))
            && $stable(SIGN_WRAP_OUT) && $stable(ARITH_WRAP_OUT) && $stable(NIBBLE_WRAP_OUT))
        else $error("and with memory result or flags wrong");
    chk_and_lit_work: assert property (
        take && OP_CODE_IN == OP_AND_LIT_TO_WORK |=>
            WORK_REG_OUT == ($past(work_q) & $past(LITERAL_IN))
            && NULL_RESULT_OUT == (WORK_REG_OUT == ZERO_BYTE) && $stable(ARITH_WRAP_OUT))
        else $error("and with literal result or flags wrong");
    chk_and_into_mem: assert property (
        take && OP_CODE_IN == OP_AND_INTO_MEMORY |=> MEM_WE_OUT
            && MEM_WDATA_OUT == ($past(work_q) & $past(MEM_RDATA_IN)))
        else $error("and into memory result wrong");
    chk_call_push_load: assert property (
        s_call_taken |=> STACK_DATA_OUT == PC_W'($past(PC_IN) + PC_W'(RET_STEP))
            ##1 PC_VALUE_OUT == $past(CALL_TARGET_IN, 2))
        else $error("call return address or target wrong");
    chk_call_two_cycles: assert property (
        s_call_taken |=> s_call_body ##0 DONE_OUT ##1 !PC_LOAD_OUT)
        else $error("call did not complete in two cycles");
    chk_call_flags_kept: assert property (
        s_call_taken |=> ($stable(NULL_RESULT_OUT) && $stable(ARITH_WRAP_OUT)
            && $stable(WORK_REG_OUT))[*2])
        else $error("call changed flags");
    chk_zero_byte: assert property (
        take && OP_CODE_IN == OP_ZERO_WRITE_BYTE |=> MEM_WE_OUT && MEM_WDATA_OUT == ZERO_BYTE
            && $stable(NULL_RESULT_OUT) && $stable(SIGN_WRAP_OUT))
        else $error("byte zero-write wrong");
    chk_zero_bit: assert property (
        take && OP_CODE_IN == OP_ZERO_WRITE_BIT |=> MEM_WE_OUT && $stable(NULL_RESULT_OUT)
            && MEM_WDATA_OUT == ($past(MEM_RDATA_IN) & ~(ONE_BIT_MASK << $past(BIT_SEL_IN))))
        else $error("bit zero-write wrong");
    chk_wdog_clear: assert property (
        take && OP_CODE_IN == OP_WDOG_CLEAR && !EXPIRY_SET_IN && !SLEEP_SET_IN |=>
            WDOG_COUNT_OUT == '0 && !WDOG_EXPIRY_OUT && !SLEEP_ENTRY_OUT)
        else $error("watchdog clear incomplete");
    chk_and_mem_null: assert property (
        take && OP_CODE_IN == OP_AND_INTO_MEMORY |=> $stable(WORK_REG_OUT)
            && NULL_RESULT_OUT == (MEM_WDATA_OUT == ZERO_BYTE) && $stable(SIGN_WRAP_OUT))
        else $error("and into memory flags wrong");
endmodule

// ===== sim/tb_mie_core.sv
/*
 * Self-checking bench for mie_core: drives operations word by word and
 * compares results, flags, pulses and watchdog state with a small model.
 * Assumes the package mie_pkg and the default core parameters.
 */
module tb_mie_core
    import mie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rstn = 1'b0, vld = 1'b0, tick = 1'b0, ex_set = 1'b0, sl_set = 1'b0;
    logic [OP_W-1:0] op = 4'h0;
    logic [7:0] addr = 8'h00, rdata = 8'h00, lit = 8'h00;
    logic [2:0] bsel = 3'h0;
    logic [11:0] tgt = 12'h000, pc = 12'h000;
    logic [7:0] work, maddr, wdata;
    logic sgn, nul, nib, arw, we, push, pcld, busy, done, wexp, slp;
    logic [11:0] sdata, pcv;
    logic [15:0] wcnt;
    logic [7:0] e_work = WORK_RST;
    logic e_sgn = 1'b0, e_nul = 1'b0, e_nib = 1'b0, e_arw = 1'b0;
    int failures = 0;
    int n_tests = 0;

    mie_core i_dut (.CLK_IN(clk), .RSTN_IN(rstn), .OP_VALID_IN(vld), .OP_CODE_IN(op),
        .MEM_ADDR_IN(addr), .MEM_RDATA_IN(rdata), .LITERAL_IN(lit), .BIT_SEL_IN(bsel),
        .CALL_TARGET_IN(tgt), .PC_IN(pc), .WDOG_TICK_IN(tick), .EXPIRY_SET_IN(ex_set),
        .SLEEP_SET_IN(sl_set), .WORK_REG_OUT(work), .SIGN_WRAP_OUT(sgn),
        .NULL_RESULT_OUT(nul), .NIBBLE_WRAP_OUT(nib), .ARITH_WRAP_OUT(arw),
        .MEM_WE_OUT(we), .MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(wdata),
        .STACK_PUSH_OUT(push), .STACK_DATA_OUT(sdata), .PC_LOAD_OUT(pcld),
        .PC_VALUE_OUT(pcv), .BUSY_OUT(busy), .DONE_OUT(done), .WDOG_COUNT_OUT(wcnt),
        .WDOG_EXPIRY_OUT(wexp), .SLEEP_ENTRY_OUT(slp));

    always #50 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_flags();
        check("work", {8'h00, work}, {8'h00, e_work});
        check("flags", {12'h000, sgn, nul, nib, arw}, {12'h000, e_sgn, e_nul, e_nib, e_arw});
    endtask

    // One operation word, checked in the cycle after the taking edge
    task automatic do_op(input logic [3:0] o, input logic [7:0] d, input logic [7:0] l,
                         input logic [2:0] b);
        logic [8:0] s;
        logic [7:0] e_wd;
        logic e_we;
        s = {1'b0, d} + {1'b0, e_work};
        e_we = 1'b1;
        e_wd = 8'h00;
        @(posedge clk);
        vld <= 1'b1;
        op <= o;
        addr <= d ^ 8'h3c;
        rdata <= d;
        lit <= l;
        bsel <= b;
        @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
        case (o)
            OP_ADD_INTO_MEMORY: begin
                e_wd = s[7:0];
                e_arw = s[8];
                e_nib = ({1'b0, d[3:0]} + {1'b0, e_work[3:0]}) > 5'h0f;
                e_sgn = s[8] ^ (({1'b0, d[6:0]} + {1'b0, e_work[6:0]}) > 8'h7f);
                e_nul = s[7:0] == 8'h00;
            end
            OP_AND_MEM_TO_WORK, OP_AND_LIT_TO_WORK: begin
                e_we = 1'b0;
                e_work = e_work & ((o == OP_AND_MEM_TO_WORK) ? d : l);
                e_nul = e_work == 8'h00;
            end
            OP_AND_INTO_MEMORY: begin
                e_wd = d & e_work;
                e_nul = e_wd == 8'h00;
            end
            OP_ZERO_WRITE_BIT: e_wd = d & ~(8'h01 << b);
            OP_ZERO_WRITE_BYTE: e_wd = 8'h00;
            default: e_we = 1'b0;
        endcase
        check("done", {15'h0, done}, 16'h0001);
        check("mem write", {15'h0, we}, {15'h0, e_we});
        if (e_we) begin
            check("wdata", {maddr, wdata}, {d ^ 8'h3c, e_wd});
        end
        check_flags();
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        check("reset state", {1'b0, we, push, pcld, busy, done, wexp, slp, work},
            {8'h00, WORK_RST});
        check_flags();
        do_op(OP_ADD_INTO_MEMORY, 8'h00, 8'h00, 3'h0);
        do_op(OP_ADD_INTO_MEMORY, 8'hff, 8'h00, 3'h0);
        do_op(OP_AND_MEM_TO_WORK, 8'hf3, 8'h00, 3'h0);
        do_op(OP_ADD_INTO_MEMORY, 8'h80, 8'h00, 3'h0);
        do_op(OP_AND_LIT_TO_WORK, 8'h00, 8'h0f, 3'h0);
        do_op(OP_ADD_INTO_MEMORY, 8'h55, 8'h00, 3'h0);
        do_op(OP_AND_INTO_MEMORY, 8'hf0, 8'h00, 3'h0);
        do_op(OP_ADD_INTO_MEMORY, 8'h01, 8'h00, 3'h0);
        do_op(OP_AND_LIT_TO_WORK, 8'hff, 8'hf0, 3'h0);
        do_op(OP_ZERO_WRITE_BYTE, 8'h5a, 8'h00, 3'h0);
        for (int i = 0; i < 8; i++) begin
            do_op(OP_ZERO_WRITE_BIT, 8'hff, 8'h00, i[2:0]);
        end
        do_op(4'hf, 8'h33, 8'h00, 3'h0);
        // Call held with a second word that must be refused while busy
        @(posedge clk);
        vld <= 1'b1;
        op <= OP_CALL;
        pc <= 12'h0ff;
        tgt <= 12'habc;
        @(posedge clk);
        op <= OP_ZERO_WRITE_BYTE;
        @(negedge clk);
        check("call push", {push, busy, pcld, done, sdata}, {4'hc, 12'h100});
        @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
        check("call load", {pcld, done, busy, we, pcv}, {4'hc, 12'habc});
        check_flags();
        // Watchdog: three ticks with both flags set, then one clear
        @(posedge clk);
        tick <= 1'b1;
        ex_set <= 1'b1;
        sl_set <= 1'b1;
        repeat (3) @(posedge clk);
        tick <= 1'b0;
        ex_set <= 1'b0;
        sl_set <= 1'b0;
        @(negedge clk);
        check("wdog before", {wexp, slp, wcnt[13:0]}, {2'b11, 14'h0003});
        do_op(OP_WDOG_CLEAR, 8'h00, 8'h00, 3'h0);
        check("wdog after", {wexp, slp, wcnt[13:0]}, 16'h0000);
        check("wdog high", {14'h0, wcnt[15:14]}, 16'h0000);
        // Clear meeting a tick and an expiry set: count clears, the set is kept
        @(posedge clk);
        tick <= 1'b1;
        ex_set <= 1'b1;
        do_op(OP_WDOG_CLEAR, 8'h00, 8'h00, 3'h0);
        check("wdog set wins", {wexp, slp, wcnt[13:0]}, {2'b10, 14'h0000});
        // Reset again in mid-run: pulses, watchdog, working register and flags back to their reset values
        @(posedge clk);
        tick <= 1'b0;
        ex_set <= 1'b0;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        e_work = WORK_RST;
        e_sgn = FLAG_RST;
        e_nul = FLAG_RST;
        e_nib = FLAG_RST;
        e_arw = FLAG_RST;
        check("reset again", {1'b0, we, push, pcld, busy, done, wexp, slp, work},
            {8'h00, WORK_RST});
        check("reset count", wcnt, 16'h0000);
        check_flags();
        test_done();
    end
endmodule
